// File: two_level_interrupt_arbiter.sv
// Contract
// R1 - bit 3 sets watchdog, dram, adc level
// R2 - bit 2 sets timer channel 0 level
// R3 - bit 1 sets timer channel 1 level
// R4 - bit 0 sets timer channel 2 level
// R5 - condition forwarded only while enable set
// R6 - pick highest level, keep others pending
// R7 - equal levels resolved by fixed order
// R8 - mask clear accepts any selected request
// R9 - mask set, user clear: nmi, level1
// R10 - both masks set: only nmi accepted
// R11 - entry starts after current instruction completes
// R12 - push pc then condition codes
// R13 - entry sets both mask bits
// R14 - vector address issued, jump to contents
// R15 - two-level scheme only when ube clear
// R16 - tie order is a parameter table
`timescale 1ns/1ns
module two_level_interrupt_arbiter
    import intc_pkg::*;
#(
    parameter logic [SRC_N-1:0][RANK_W-1:0] SRC_RANK = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
    parameter logic [SRC_N-1:0][VEC_NW-1:0] SRC_VEC  = {8'h25, 8'h24, 8'h23, 8'h22, 8'h21, 8'h20},
    parameter logic [VEC_NW-1:0]            NMI_VEC  = 8'h07
) (
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 arst_n_i,
    // register port
    input  wire reg_req_t             reg_req_i,
    output logic        [DATA_W-1:0]  rdata_o,
    // peripheral conditions and nmi pin
    input  wire logic   [SRC_N-1:0]   cond_i,
    input  wire logic                 nmi_i,
    output logic        [SRC_N-1:0]   src_ack_o,
    output logic                      nmi_ack_o,
    // core side
    input  wire logic                 i_mask_i,
    input  wire logic                 user_mask_bit_i,
    input  wire logic   [CCR_W-1:0]   ccr_i,
    input  wire logic   [ADDR_W-1:0]  next_pc_i,
    input  wire logic                 insn_done_i,
    input  wire logic   [ADDR_W-1:0]  vec_data_i,
    output stack_word_t               stack_o,
    output logic                      mask_set_o,
    output logic                      vec_rd_o,
    output logic        [ADDR_W-1:0]  vec_addr_o,
    output logic                      jump_o,
    output logic        [ADDR_W-1:0]  jump_addr_o,
    output logic                      busy_o,
    output logic                      irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks on the rank table
    for (genvar g = 0; g < SRC_N; g++) begin : g_chk
        if (SRC_RANK[g] >= RANK_W'(SRC_N)) begin : g_bad
            $error("tie rank out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // nmi pin synchroniser and edge detect
    logic nmi_s1_ff;
    logic nmi_s2_ff;
    logic nmi_s3_ff;
    logic nmi_edge;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nmi_s1_ff <= 1'b0;
            nmi_s2_ff <= 1'b0;
            nmi_s3_ff <= 1'b0;
        end else begin
            nmi_s1_ff <= nmi_i;
            nmi_s2_ff <= nmi_s1_ff;
            nmi_s3_ff <= nmi_s2_ff;
        end
    end

    assign nmi_edge = nmi_s2_ff & ~nmi_s3_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    logic [PRIO_FIELD_W-1:0] prio_ff;
    logic [PRIO_FIELD_W-1:0] nxt_prio;
    logic [SRC_N-1:0]        ien_ff;
    logic [SRC_N-1:0]        nxt_ien;
    logic                    ube_ff;
    logic                    nxt_ube;
    logic [EVT_W-1:0]        evt_ff;
    logic [EVT_W-1:0]        nxt_evt;
    logic [EVT_W-1:0]        evm_ff;
    logic [EVT_W-1:0]        nxt_evm;
    logic [DATA_W-1:0]       rdata_ff;
    logic [DATA_W-1:0]       nxt_rdata;
    logic                    irq_ff;
    logic                    nxt_irq;
    logic [EVT_W-1:0]        evt_set;

    ////////////////////////////////////////////////////////////////////////////////
    // request gating, levels and selection
    logic [SRC_N-1:0]  req;
    logic [SRC_N-1:0]  lvl;
    logic              sel_valid;
    logic [SRC_W-1:0]  sel_idx;
    logic              sel_lvl;
    logic [RANK_W-1:0] sel_rank;
    logic              accept_ok;

    // requests pass only with enable set
    assign req = cond_i & ien_ff; // R5

    // per-source level from the priority field
    assign lvl[SRC_WDT]  = prio_ff[PRIO_SEL_WDT_DRAM_ADC]; // R1
    assign lvl[SRC_DRAM] = prio_ff[PRIO_SEL_WDT_DRAM_ADC]; // R1
    assign lvl[SRC_ADC]  = prio_ff[PRIO_SEL_WDT_DRAM_ADC]; // R1
    assign lvl[SRC_TMR0] = prio_ff[PRIO_SEL_TIMER_CH0];    // R2
    assign lvl[SRC_TMR1] = prio_ff[PRIO_SEL_TIMER_CH1];    // R3
    assign lvl[SRC_TMR2] = prio_ff[PRIO_SEL_TIMER_CH2];    // R4

    // highest level wins, rank table breaks ties
    always_comb begin
        sel_valid = 1'b0;
        sel_idx   = '0;
        sel_lvl   = 1'b0;
        sel_rank  = '1;
        for (int i = 0; i < SRC_N; i++) begin
            if (req[i] && (!sel_valid || (lvl[i] && !sel_lvl) // R6
                || (lvl[i] == sel_lvl && SRC_RANK[i] < sel_rank))) begin // R7 R16
                sel_valid = 1'b1;
                sel_idx   = SRC_W'(i);
                sel_lvl   = lvl[i];
                sel_rank  = SRC_RANK[i];
            end
        end
    end

    // acceptance by core mask bits
    always_comb begin
        if (!i_mask_i) begin
            accept_ok = sel_valid; // R8
        end else if (!ube_ff && !user_mask_bit_i) begin
            accept_ok = sel_valid && sel_lvl; // R9 R15
        end else begin
            accept_ok = 1'b0; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // exception entry sequencer state
    entry_state_t      st_ff;
    entry_state_t      nxt_st;
    logic              nmi_pend_ff;
    logic              nxt_nmi_pend;
    logic [SRC_W-1:0]  src_ff;
    logic [SRC_W-1:0]  nxt_src;
    logic [ADDR_W-1:0] pc_ff;
    logic [ADDR_W-1:0] nxt_pc;
    logic [CCR_W-1:0]  ccr_ff;
    logic [CCR_W-1:0]  nxt_ccr;
    stack_word_t       stack_ff;
    stack_word_t       nxt_stack;
    logic              mask_set_ff;
    logic              nxt_mask_set;
    logic              vec_rd_ff;
    logic              nxt_vec_rd;
    logic [ADDR_W-1:0] vec_addr_ff;
    logic [ADDR_W-1:0] nxt_vec_addr;
    logic              jump_ff;
    logic              nxt_jump;
    logic [ADDR_W-1:0] jump_addr_ff;
    logic [ADDR_W-1:0] nxt_jump_addr;
    logic [SRC_N-1:0]  src_ack_ff;
    logic [SRC_N-1:0]  nxt_src_ack;
    logic              nmi_ack_ff;
    logic              nxt_nmi_ack;
    logic              take_nmi;
    logic              take_mask;
    logic [VEC_NW-1:0] vec_no;
    logic              busy_ff;
    logic              nxt_busy;

    assign take_nmi  = (st_ff == ST_IDLE) && nmi_pend_ff;
    assign take_mask = (st_ff == ST_IDLE) && !nmi_pend_ff && accept_ok;
    assign vec_no    = (src_ff == SRC_NMI) ? NMI_VEC : SRC_VEC[src_ff];

    // next state and outputs of the entry sequence
    always_comb begin
        nxt_st        = st_ff;
        nxt_src       = src_ff;
        nxt_pc        = pc_ff;
        nxt_ccr       = ccr_ff;
        nxt_stack     = '0;
        nxt_mask_set  = 1'b0;
        nxt_vec_rd    = 1'b0;
        nxt_vec_addr  = vec_addr_ff;
        nxt_jump      = 1'b0;
        nxt_jump_addr = jump_addr_ff;
        nxt_src_ack   = '0;
        nxt_nmi_ack   = 1'b0;
        // a new edge wins over the clear at acceptance
        nxt_nmi_pend  = (nmi_pend_ff && !take_nmi) || nmi_edge;
        case (st_ff)
            ST_IDLE: begin
                if (take_nmi) begin
                    nxt_src     = SRC_NMI;
                    nxt_nmi_ack = 1'b1;
                    nxt_st      = ST_WAIT_INSN;
                end else if (take_mask) begin
                    nxt_src              = sel_idx;
                    nxt_src_ack[sel_idx] = 1'b1;
                    nxt_st               = ST_WAIT_INSN;
                end
            end
            ST_WAIT_INSN: begin
                if (insn_done_i) begin // R11
                    nxt_pc  = next_pc_i;
                    nxt_ccr = ccr_i;
                    nxt_st  = ST_PUSH_PC;
                end
            end
            ST_PUSH_PC: begin
                nxt_stack = '{valid: 1'b1, is_ccr: 1'b0, data: pc_ff}; // R12
                nxt_st    = ST_PUSH_CCR;
            end
            ST_PUSH_CCR: begin
                nxt_stack = '{valid: 1'b1, is_ccr: 1'b1, data: ADDR_W'(ccr_ff)}; // R12
                nxt_st    = ST_MASK;
            end
            ST_MASK: begin
                nxt_mask_set = 1'b1; // R13
                nxt_vec_rd   = 1'b1;
                nxt_vec_addr = VEC_BASE + ADDR_W'({vec_no, 2'b00}); // R14
                nxt_st       = ST_VEC_WAIT;
            end
            ST_VEC_WAIT: begin
                nxt_st = ST_VEC_TAKE;
            end
            ST_VEC_TAKE: begin
                nxt_jump      = 1'b1; // R14
                nxt_jump_addr = vec_data_i;
                nxt_st        = ST_IDLE;
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        nxt_busy      = (nxt_st != ST_IDLE);
    end

    // entry sequencer registers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff        <= ST_IDLE;
            nmi_pend_ff  <= 1'b0;
            src_ff       <= '0;
            pc_ff        <= '0;
            ccr_ff       <= '0;
            stack_ff     <= '0;
            mask_set_ff  <= 1'b0;
            vec_rd_ff    <= 1'b0;
            vec_addr_ff  <= '0;
            jump_ff      <= 1'b0;
            jump_addr_ff <= '0;
            src_ack_ff   <= '0;
            nmi_ack_ff   <= 1'b0;
            busy_ff      <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            nmi_pend_ff  <= nxt_nmi_pend;
            src_ff       <= nxt_src;
            pc_ff        <= nxt_pc;
            ccr_ff       <= nxt_ccr;
            stack_ff     <= nxt_stack;
            mask_set_ff  <= nxt_mask_set;
            vec_rd_ff    <= nxt_vec_rd;
            vec_addr_ff  <= nxt_vec_addr;
            jump_ff      <= nxt_jump;
            jump_addr_ff <= nxt_jump_addr;
            src_ack_ff   <= nxt_src_ack;
            nmi_ack_ff   <= nxt_nmi_ack;
            busy_ff      <= nxt_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file next values, sticky events, interrupt line
    always_comb begin
        nxt_prio  = prio_ff;
        nxt_ien   = ien_ff;
        nxt_ube   = ube_ff;
        nxt_evm   = evm_ff;
        nxt_rdata = '0;
        evt_set            = '0;
        evt_set[EVT_ENTRY] = (st_ff == ST_VEC_TAKE);
        evt_set[EVT_NMI]   = nmi_edge;
        evt_set[EVT_HELD]  = (st_ff == ST_IDLE) && sel_valid && !accept_ok;
        nxt_evt   = evt_ff;
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                REG_PRIO: nxt_prio = reg_req_i.wdata[PRIO_FIELD_W-1:0];
                REG_IEN:  nxt_ien  = reg_req_i.wdata[SRC_N-1:0];
                REG_CTRL: nxt_ube  = reg_req_i.wdata[CTRL_UBE_BIT];
                REG_EVT:  nxt_evt  = evt_ff & ~reg_req_i.wdata[EVT_W-1:0];
                REG_EVM:  nxt_evm  = reg_req_i.wdata[EVT_W-1:0];
                default:  nxt_evt  = evt_ff;
            endcase
        end
        // set wins over a clear in the same cycle
        nxt_evt = nxt_evt | evt_set;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                REG_PRIO: nxt_rdata = DATA_W'(prio_ff);
                REG_IEN:  nxt_rdata = DATA_W'(ien_ff);
                REG_CTRL: nxt_rdata = DATA_W'(ube_ff);
                REG_EVT:  nxt_rdata = DATA_W'(evt_ff);
                REG_EVM:  nxt_rdata = DATA_W'(evm_ff);
                REG_REQ:  nxt_rdata = DATA_W'(req);
                REG_STAT: nxt_rdata = {nmi_pend_ff, src_ff, 1'b0, st_ff};
                default:  nxt_rdata = '0;
            endcase
        end
        nxt_irq = |(nxt_evt & nxt_evm);
    end

    // register file flops
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio_ff  <= PRIO_RST[PRIO_FIELD_W-1:0];
            ien_ff   <= IEN_RST[SRC_N-1:0];
            ube_ff   <= CTRL_RST[CTRL_UBE_BIT];
            evt_ff   <= '0;
            evm_ff   <= EVM_RST[EVT_W-1:0];
            rdata_ff <= '0;
            irq_ff   <= 1'b0;
        end else begin
            prio_ff  <= nxt_prio;
            ien_ff   <= nxt_ien;
            ube_ff   <= nxt_ube;
            evt_ff   <= nxt_evt;
            evm_ff   <= nxt_evm;
            rdata_ff <= nxt_rdata;
            irq_ff   <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_o     = rdata_ff;
    assign src_ack_o   = src_ack_ff;
    assign nmi_ack_o   = nmi_ack_ff;
    assign stack_o     = stack_ff;
    assign mask_set_o  = mask_set_ff;
    assign vec_rd_o    = vec_rd_ff;
    assign vec_addr_o  = vec_addr_ff;
    assign jump_o      = jump_ff;
    assign jump_addr_o = jump_addr_ff;
    assign busy_o      = busy_ff;
    assign irq_o       = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    a_grp_a_level: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R1
        sel_valid && sel_idx <= SRC_ADC |-> sel_lvl == prio_ff[PRIO_SEL_WDT_DRAM_ADC])
        else $error("watchdog group level does not follow bit 3");
    a_tmr2_level: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R4
        sel_valid && sel_idx == SRC_TMR2 |-> sel_lvl == prio_ff[PRIO_SEL_TIMER_CH2])
        else $error("timer 2 level does not follow bit 0");
    a_ack_enabled: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R5
        |src_ack_o |-> (src_ack_o & ~ien_ff) == '0 || $past(reg_req_i.wr))
        else $error("disabled source acknowledged");
    a_sel_highest: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R6
        sel_valid && !sel_lvl |-> (req & lvl) == '0)
        else $error("low level chosen over a high level request");
    a_open_accept: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R8
        st_ff == ST_IDLE && !i_mask_i && sel_valid |=> st_ff == ST_WAIT_INSN)
        else $error("request not accepted with mask clear");
    a_level1_pass: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R9
        st_ff == ST_IDLE && i_mask_i && !user_mask_bit_i && !ube_ff && !nmi_pend_ff
        && sel_valid |=> (st_ff == ST_WAIT_INSN) == $past(sel_lvl))
        else $error("level gating wrong with user mask clear");
    a_nmi_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R10
        st_ff == ST_IDLE && i_mask_i && user_mask_bit_i && !nmi_pend_ff
        |=> st_ff == ST_IDLE && src_ack_o == '0)
        else $error("maskable request taken with both masks set");
    a_ube_single: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R15
        st_ff == ST_IDLE && i_mask_i && ube_ff && !nmi_pend_ff |=> st_ff == ST_IDLE)
        else $error("second mask level used while ube set");
    a_wait_insn: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R11
        st_ff == ST_WAIT_INSN && !insn_done_i |=> st_ff == ST_WAIT_INSN && !stack_o.valid)
        else $error("entry began before instruction completed");
    a_push_order: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R12 R13
        st_ff == ST_PUSH_PC |=> (stack_o.valid && !stack_o.is_ccr && stack_o.data == pc_ff)
        ##1 (stack_o.valid && stack_o.is_ccr) ##1 (mask_set_o && !stack_o.valid))
        else $error("entry push or mask order wrong");
    a_vec_jump: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R14
        vec_rd_o |=> ##1 jump_o && jump_addr_o == $past(vec_data_i))
        else $error("jump does not use vector contents");
endmodule

// File: intc_pkg.sv
package intc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int SRC_N  = 6;   // maskable sources
    localparam int SRC_W  = 3;   // source index width
    localparam int DATA_W = 8;   // register data width
    localparam int REG_AW = 4;   // register address width
    localparam int ADDR_W = 24;  // core address width
    localparam int CCR_W  = 8;   // condition code register width
    localparam int VEC_NW = 8;   // vector number width
    localparam int RANK_W = 3;   // tie-break rank width

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [REG_AW-1:0] REG_PRIO = 4'h0; // interrupt_priority_a
    localparam logic [REG_AW-1:0] REG_IEN  = 4'h1; // per-source enable bits
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h2; // user_bit_enable
    localparam logic [REG_AW-1:0] REG_EVT  = 4'h3; // sticky events, write 1 clears
    localparam logic [REG_AW-1:0] REG_EVM  = 4'h4; // event mask
    localparam logic [REG_AW-1:0] REG_REQ  = 4'h5; // live requests, read only
    localparam logic [REG_AW-1:0] REG_STAT = 4'h6; // entry state, read only

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PRIO_SEL_WDT_DRAM_ADC = 3;
    localparam int PRIO_SEL_TIMER_CH0    = 2;
    localparam int PRIO_SEL_TIMER_CH1    = 1;
    localparam int PRIO_SEL_TIMER_CH2    = 0;
    localparam int PRIO_FIELD_W          = 4;
    localparam int CTRL_UBE_BIT          = 0;
    localparam int EVT_ENTRY             = 0; // exception entry finished
    localparam int EVT_NMI               = 1; // nmi edge seen
    localparam int EVT_HELD              = 2; // request held pending by masks
    localparam int EVT_W                 = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // source indices
    localparam logic [SRC_W-1:0] SRC_WDT  = 3'h0;
    localparam logic [SRC_W-1:0] SRC_DRAM = 3'h1;
    localparam logic [SRC_W-1:0] SRC_ADC  = 3'h2;
    localparam logic [SRC_W-1:0] SRC_TMR0 = 3'h3;
    localparam logic [SRC_W-1:0] SRC_TMR1 = 3'h4;
    localparam logic [SRC_W-1:0] SRC_TMR2 = 3'h5;
    localparam logic [SRC_W-1:0] SRC_NMI  = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [DATA_W-1:0] PRIO_RST = 8'h00;
    localparam logic [DATA_W-1:0] IEN_RST  = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] EVM_RST  = 8'h00;
    localparam logic [ADDR_W-1:0] VEC_BASE = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [REG_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic              valid;
        logic              is_ccr;
        logic [ADDR_W-1:0] data;
    } stack_word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_INSN,
        ST_PUSH_PC,
        ST_PUSH_CCR,
        ST_MASK,
        ST_VEC_WAIT,
        ST_VEC_TAKE
    } entry_state_t;

endpackage

// File: core_model.sv
`timescale 1ns/1ns
module core_model
    import intc_pkg::*;
#(
    parameter logic [ADDR_W-1:0] PC_VAL  = 24'h00_1234,
    parameter logic [CCR_W-1:0]  CCR_VAL = 8'h5a,
    parameter logic [ADDR_W-1:0] VDAT_X  = 24'h5a_0000
) (
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    // bench control
    input  wire logic              load_i,
    input  wire logic [1:0]        mask_i,
    input  wire logic [3:0]        lat_i,
    // block side
    input  wire logic              ack_i,
    input  wire logic              mask_set_i,
    input  wire logic              vec_rd_i,
    input  wire logic [ADDR_W-1:0] vec_addr_i,
    output logic      [1:0]        mask_o,
    output logic                   insn_done_o,
    output logic      [ADDR_W-1:0] next_pc_o,
    output logic      [CCR_W-1:0]  ccr_o,
    output logic      [ADDR_W-1:0] vec_data_o
);
    logic              armed_ff;
    logic [3:0]        cnt_ff;
    logic              rd_ff;
    logic [ADDR_W-1:0] vdat_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // outputs valid only when due, inverted otherwise
    assign insn_done_o = armed_ff && cnt_ff == 4'h0;
    assign next_pc_o   = insn_done_o ? PC_VAL : ~PC_VAL;
    assign ccr_o       = insn_done_o ? CCR_VAL : ~CCR_VAL;
    assign vec_data_o  = rd_ff ? vdat_ff : ~vdat_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // instruction end timer, mask bits, vector fetch
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed_ff <= 1'b0;
            cnt_ff   <= 4'h0;
            rd_ff    <= 1'b0;
            vdat_ff  <= '0;
            mask_o   <= 2'b00;
        end else begin
            if (ack_i) begin
                armed_ff <= 1'b1;
                cnt_ff   <= lat_i;
            end else if (insn_done_o) begin
                armed_ff <= 1'b0;
            end else if (armed_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
            rd_ff   <= vec_rd_i;
            vdat_ff <= vec_addr_i ^ VDAT_X;
            if (load_i) begin
                mask_o <= mask_i;
            end else if (mask_set_i) begin
                mask_o <= 2'b11;
            end
        end
    end
endmodule

// File: two_level_interrupt_arbiter_tb.sv
`timescale 1ns/1ns
module two_level_interrupt_arbiter_tb;
    import intc_pkg::*;
    localparam logic [ADDR_W-1:0] VDAT_X = 24'h5a_0000;
    localparam logic [ADDR_W-1:0] PC     = 24'h00_1234;
    logic              core_clk_i = 1'b0;
    logic              arst_n_i   = 1'b0;
    reg_req_t          req        = '0;
    logic [SRC_N-1:0]  cond       = '0;
    logic              nmi        = 1'b0;
    logic              load       = 1'b0;
    logic [1:0]        mask_w     = 2'b00;
    logic [3:0]        lat        = 4'h0;
    logic [DATA_W-1:0] rdata;
    logic [SRC_N-1:0]  src_ack;
    logic              nmi_ack, mask_set, vec_rd, jump, busy, irq, insn_done;
    logic [1:0]        mask;
    logic [CCR_W-1:0]  condition_code_register;
    logic [ADDR_W-1:0] next_pc, vec_data, vec_addr, jump_addr;
    stack_word_t       stack;
    logic [3:0]        ev;
    int                err_total  = 0;
    int                checked    = 0;
    assign ev = {~busy, jump, stack.valid, (|src_ack) | nmi_ack};
    always #5 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    two_level_interrupt_arbiter u_two_level_interrupt_arbiter (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(req), .rdata_o(rdata),
        .cond_i(cond), .nmi_i(nmi), .src_ack_o(src_ack), .nmi_ack_o(nmi_ack),
        .i_mask_i(mask[1]), .user_mask_bit_i(mask[0]), .ccr_i(condition_code_register), .next_pc_i(next_pc),
        .insn_done_i(insn_done), .vec_data_i(vec_data), .stack_o(stack),
        .mask_set_o(mask_set), .vec_rd_o(vec_rd), .vec_addr_o(vec_addr), .jump_o(jump),
        .jump_addr_o(jump_addr), .busy_o(busy), .irq_o(irq));
    core_model #(.PC_VAL(PC), .CCR_VAL(8'h5a), .VDAT_X(VDAT_X)) u_core_model (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .load_i(load), .mask_i(mask_w),
        .lat_i(lat), .ack_i((|src_ack) | nmi_ack), .mask_set_i(mask_set), .vec_rd_i(vec_rd),
        .vec_addr_i(vec_addr), .mask_o(mask), .insn_done_o(insn_done), .next_pc_o(next_pc),
        .ccr_o(condition_code_register), .vec_data_o(vec_data));
    ////////////////////////////////////////////////////////////////////////////////
    // report and compare
    task automatic test_done();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // register port cycles
    task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge core_clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_i);
        req.rd <= 1'b0;
        #1;
        chk_reg(rdata, exp);
    endtask
    // bounded wait on one event line
    task automatic wait_ev(input int k, output int n);
        n = 0;
        while (ev[k] !== 1'b1) begin
            @(posedge core_clk_i);
            #1;
            n++;
            if (n > 40) begin
                err_total++;
                $display("BAD %0t timeout", $time);
                test_done();
            end
        end
    endtask
    // all maskable sources raised, nmi per nm; either refused or a full entry is followed
    task automatic entry(input logic [3:0] prio, input logic [1:0] msk, input logic nm,
                         input logic [2:0] src, input logic take, input logic [3:0] dly);
        int                n;
        logic [ADDR_W-1:0] va;
        wr_reg(REG_PRIO, {4'h0, prio});
        @(posedge core_clk_i);
        load   <= 1'b1;
        mask_w <= msk;
        lat    <= dly;
        @(posedge core_clk_i);
        load <= 1'b0;
        cond <= 6'h3f;
        nmi  <= nm;
        if (!take) begin
            n = 0;
            repeat (15) begin
                @(posedge core_clk_i);
                #1;
                n += int'(ev[0] === 1'b1);
            end
            chk_val(24'(n), 24'h0);
        end else begin
            wait_ev(0, n);
            chk_val({17'h0, nmi_ack, src_ack}, src == SRC_NMI ? 24'h40 : 24'(1) << src);
            wait_ev(1, n);
            chk_val(24'(n > int'(dly)), 24'h1);
            chk_val({stack.is_ccr, stack.data[22:0]}, PC);
            @(posedge core_clk_i);
            #1;
            chk_val({stack.valid, stack.is_ccr, 14'h0, stack.data[7:0]}, 24'hc0_005a);
            wait_ev(2, n);
            chk_val({22'h0, mask}, 24'h3);
            va = VEC_BASE + {14'h0, (src == SRC_NMI) ? 8'h07 : 8'h20 + 8'(src), 2'b00};
            chk_val(vec_addr, va);
            chk_val(jump_addr, va ^ VDAT_X);
        end
        @(posedge core_clk_i);
        cond <= '0;
        nmi  <= 1'b0;
        wait_ev(3, n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    initial begin
        #1_000_000;
        err_total++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(4'(a), 8'h00);
        wr_reg(REG_PRIO, 8'hff);
        rd_chk(REG_PRIO, 8'h0f);
        entry(4'hf, 2'b00, 1'b0, SRC_WDT, 1'b0, 4'h0);
        wr_reg(REG_IEN, 8'h3f);
        entry(4'h0, 2'b01, 1'b0, SRC_WDT, 1'b1, 4'h0);
        entry(4'h8, 2'b10, 1'b0, SRC_WDT, 1'b1, 4'h3);
        entry(4'h4, 2'b10, 1'b0, SRC_TMR0, 1'b1, 4'h7);
        entry(4'h2, 2'b10, 1'b0, SRC_TMR1, 1'b1, 4'h0);
        entry(4'h1, 2'b10, 1'b0, SRC_TMR2, 1'b1, 4'h9);
        entry(4'h0, 2'b10, 1'b0, SRC_WDT, 1'b0, 4'h0);
        rd_chk(REG_EVT, 8'h05);
        chk_val({23'h0, irq}, 24'h0);
        wr_reg(REG_EVM, 8'h01);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk_val({23'h0, irq}, 24'h1);
        wr_reg(REG_EVT, 8'h07);
        rd_chk(REG_EVT, 8'h00);
        chk_val({23'h0, irq}, 24'h0);
        entry(4'hf, 2'b11, 1'b0, SRC_WDT, 1'b0, 4'h0);
        entry(4'hf, 2'b11, 1'b1, SRC_NMI, 1'b1, 4'h2);
        wr_reg(REG_CTRL, 8'h01);
        entry(4'hf, 2'b10, 1'b0, SRC_WDT, 1'b0, 4'h0);
        test_done();
    end
endmodule
